// ==== verification/dsac_host_model.sv ====
// dsac_host_model.sv: host reading results, parallel or serial
// assumes: the bench calls its tasks; link clock period 15 ns
`timescale 1ns/1ps
module dsac_host_model
    import dsac_pkg::*;
(
    // system clock and device outputs
    input  wire logic        clk,
    input  wire logic [15:0] dout,
    input  wire logic [15:0] doe,
    input  wire logic        sdo,
    input  wire logic        sclk_out,
    // strobes and link clock
    output logic             cs_n,
    output logic             rd_n,
    output logic             sclk
);
    // strobes idle high, link clock idles low; outside frames only stray runs it
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        sclk = 1'b0;
    end

    // one parallel word
    task automatic par_read(output logic [15:0] w, output logic [15:0] oe);
        @(posedge clk) #1;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        w = dout;
        oe = doe;
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // slave frame: sample after each falling edge
    task automatic ser_read(input int n, input int gap, input bit keep, output dsac_frame_t w);
        @(posedge clk) #1;
        cs_n = 1'b0;
        rd_n = 1'b0;
        w = '0;
        #23.3;
        repeat (n) begin
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
            #(7.5 + 15 * gap);
            w = {w[30:0], sdo};
        end
        if (!keep) done_read();
        repeat (2) @(posedge clk);
    endtask

    task automatic done_read();
        cs_n = 1'b1;
        rd_n = 1'b1;
    endtask

    // edges with chip select off
    task automatic stray(input int n);
        repeat (n) begin
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
            #7.5;
        end
    endtask

    // master frame: bit taken at each clock rise
    task automatic int_read(output dsac_frame_t w, output int n);
        logic prev;
        @(posedge clk) #1;
        cs_n = 1'b0;
        rd_n = 1'b0;
        n = 0;
        prev = 1'b0;
        w = '0;
        repeat (80) begin
            @(posedge clk) #1;
            if (sclk_out === 1'b1 && !prev) begin
                w = {w[30:0], sdo};
                n++;
            end
            prev = sclk_out;
        end
        done_read();
    endtask
endmodule

// ==== verification/dsac_top_chk.sv ====
// dsac_top_chk.sv: pin-level checks on the control port
// assumes: bound to dsac_top; sampled on CLOCK
`timescale 1ns/1ps
module dsac_top_chk #(
    parameter int CONV_CYC = 4
) (
    input wire logic        CLOCK,
    input wire logic        RESET_N,
    input wire logic        CONVERT_START_N,
    input wire logic        POWER_DOWN,
    input wire logic        DEVICE_RESET,
    input wire logic        CS_N,
    input wire logic        RD_N,
    input wire logic        SERIAL_PARALLEL_SELECT,
    input wire logic        CLOCK_SOURCE_SELECT,
    input wire logic        READ_MODE_OR_CHAIN_IN,
    input wire logic        BUSY,
    input wire logic        END_OF_CONVERT_N,
    input wire logic [15:0] DATA_OUT,
    input wire logic [15:0] DATA_OE,
    input wire logic        SERIAL_OE,
    input wire logic        SCLK_OUT
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    // one end-of-convert low per channel, a conversion time apart
    sequence s_eocs;
        ##(CONV_CYC) !END_OF_CONVERT_N ##(CONV_CYC) !END_OF_CONVERT_N;
    endsequence

    // device reset aborts, so it disables this check
    conv_busy_a: assert property (disable iff (!RESET_N || DEVICE_RESET)
        $rose(BUSY) |-> (BUSY throughout s_eocs) ##1 !BUSY)
        else $error("busy/eoc timing wrong");
    eoc_pulse_a: assert property ($fell(END_OF_CONVERT_N) |-> BUSY ##1 END_OF_CONVERT_N)
        else $error("eoc pulse bad");
    start_cause_a: assert property ($rose(BUSY) |->
        $past(CONVERT_START_N, 2) == 1'b0 && $past(POWER_DOWN, 2) == 1'b0)
        else $error("busy without start");
    dev_abort_a: assert property (DEVICE_RESET [*5] |-> !BUSY)
        else $error("busy after device reset");
    hi_float_a: assert property (DATA_OE[15:12] ==
        {4{!SERIAL_PARALLEL_SELECT && !CS_N && !RD_N}})
        else $error("upper enables wrong");
    ser_oe_a: assert property (SERIAL_OE == (SERIAL_PARALLEL_SELECT && !CS_N && !RD_N))
        else $error("serial enable wrong");
    ovr_pulse_a: assert property (SERIAL_PARALLEL_SELECT && CLOCK_SOURCE_SELECT &&
        $rose(DATA_OUT[11]) |=> !DATA_OUT[11])
        else $error("overrun flag too long");
    sclk_hold_a: assert property (SERIAL_PARALLEL_SELECT && !CLOCK_SOURCE_SELECT &&
        !READ_MODE_OR_CHAIN_IN && BUSY |-> $stable(SCLK_OUT))
        else $error("sclk ran while busy");
endmodule
bind dsac_top dsac_top_chk #(.CONV_CYC(CONV_CYC)) u_chk (
    .CLOCK, .RESET_N, .CONVERT_START_N, .POWER_DOWN, .DEVICE_RESET, .CS_N, .RD_N,
    .SERIAL_PARALLEL_SELECT, .CLOCK_SOURCE_SELECT, .READ_MODE_OR_CHAIN_IN, .BUSY,
    .END_OF_CONVERT_N, .DATA_OUT, .DATA_OE, .SERIAL_OE, .SCLK_OUT);

// ==== verification/dsac_top_tb.sv ====
// dsac_top_tb.sv: self-checking bench
// assumes: host model and checker compiled alongside dsac_top
`timescale 1ns/1ps
module dsac_top_tb
    import dsac_pkg::*;
;
    logic        CLOCK, RESET_N, CONVERT_START_N, POWER_DOWN, IMPULSE_MODE, DEVICE_RESET;
    logic        SERIAL_PARALLEL_SELECT, CLOCK_SOURCE_SELECT, READ_MODE_OR_CHAIN_IN;
    logic        CHANNEL_ORDER_SELECT, CS_N, RD_N, SCLK_IN;
    logic [15:0] RESULT_A, RESULT_B, DATA_OUT, DATA_OE, w, oe;
    logic        BUSY, END_OF_CONVERT_N, SERIAL_RESULT_OUT, SERIAL_OE;
    dsac_frame_t f;
    int          n_errors, n_compared, n_ovr, cyc, o, n;

    dsac_top #(.CONV_CYC(4), .ACQ_CYC(3), .SCLK_HALF(1)) uut (
        .CLOCK, .RESET_N, .CONVERT_START_N, .POWER_DOWN, .IMPULSE_MODE, .DEVICE_RESET, .CS_N, .RD_N,
        .SERIAL_PARALLEL_SELECT, .CLOCK_SOURCE_SELECT, .READ_MODE_OR_CHAIN_IN, .CHANNEL_ORDER_SELECT,
        .RESULT_A, .RESULT_B, .BUSY, .END_OF_CONVERT_N, .DATA_OUT, .DATA_OE, .SCLK_IN, .SCLK_OUT(),
        .SCLK_OE(), .SERIAL_RESULT_OUT, .SERIAL_OE);

    dsac_host_model host (.clk(CLOCK), .dout(DATA_OUT), .doe(DATA_OE), .sdo(SERIAL_RESULT_OUT),
        .sclk_out(uut.SCLK_OUT), .cs_n(CS_N), .rd_n(RD_N), .sclk(SCLK_IN));

    // 10 MHz system clock
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end

    // hang guard; overrun flag cycles
    always @(posedge CLOCK) begin
        cyc++;
        if (SERIAL_PARALLEL_SELECT && CLOCK_SOURCE_SELECT && DATA_OUT[11] === 1'b1) n_ovr++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // start; busy fall = ready; keep holds start low
    task automatic convert(input logic exp, input bit keep);
        int e;
        logic seen;
        e = 0;
        seen = 1'b0;
        @(posedge CLOCK) #1;
        CONVERT_START_N = 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge CLOCK) #1;
            if (BUSY === 1'b1) seen = 1'b1;
            if (END_OF_CONVERT_N === 1'b0) e++;
            if (seen && BUSY === 1'b0) break;
        end
        check(seen, exp);
        check(e, exp ? 2 : 0);
        if (!keep) begin
            CONVERT_START_N = 1'b1;
            repeat (4) @(posedge CLOCK);
        end
    endtask

    initial begin
        {n_errors, n_compared, n_ovr, cyc} = '0;
        {CONVERT_START_N, POWER_DOWN, IMPULSE_MODE, DEVICE_RESET} = 4'h8;
        {SERIAL_PARALLEL_SELECT, CLOCK_SOURCE_SELECT, READ_MODE_OR_CHAIN_IN} = 3'h0;
        CHANNEL_ORDER_SELECT = 1'b0;
        RESULT_A = 16'hA5C3;
        RESULT_B = 16'h3C5A;
        RESET_N = 1'b0;
        repeat (8) @(posedge CLOCK);
        #1 RESET_N = 1'b1;
        repeat (4) @(posedge CLOCK);
        #1 check({BUSY, END_OF_CONVERT_N}, 2'h1);
        // power-down refuses a start
        POWER_DOWN = 1'b1;
        repeat (4) @(posedge CLOCK);
        convert(1'b0, 0);
        #1 POWER_DOWN = 1'b0;
        repeat (4) @(posedge CLOCK);
        // parallel reads in both channel orders
        for (int k = 0; k < 2; k++) begin
            #1 CHANNEL_ORDER_SELECT = k[0];
            convert(1'b1, 0);
            host.par_read(w, oe);
            check(w, k ? RESULT_B : RESULT_A);
            check(oe, 16'hFFFF);
            host.par_read(w, oe);
            check(w, k ? RESULT_A : RESULT_B);
            check(DATA_OE, 16'h0000);
        end
        // device reset aborts
        #1 CONVERT_START_N = 1'b0;
        for (int i = 0; i < 10 && BUSY !== 1'b1; i++) @(posedge CLOCK);
        #1 DEVICE_RESET = 1'b1;
        repeat (5) @(posedge CLOCK);
        #1 check(BUSY, 1'b0);
        #1 DEVICE_RESET = 1'b0;
        CONVERT_START_N = 1'b1;
        repeat (4) @(posedge CLOCK);
        // impulse: start held low converts again
        #1 IMPULSE_MODE = 1'b1;
        convert(1'b1, 1);
        for (n = 0; n < 12 && BUSY !== 1'b1; n++) @(posedge CLOCK);
        #1 check(BUSY, 1'b1);
        #1 CONVERT_START_N = 1'b1;
        repeat (20) @(posedge CLOCK);
        #1 IMPULSE_MODE = 1'b0;
        // slave serial: upper bits float, both orders
        {SERIAL_PARALLEL_SELECT, CLOCK_SOURCE_SELECT, CHANNEL_ORDER_SELECT} = 3'h6;
        repeat (4) @(posedge CLOCK);
        host.par_read(w, oe);
        check(oe[15:12], 4'h0);
        convert(1'b1, 0);
        host.ser_read(32, 0, 0, f);
        check(f, {RESULT_A, RESULT_B});
        #1 CHANNEL_ORDER_SELECT = 1'b1;
        convert(1'b1, 0);
        host.ser_read(32, 2, 0, f);
        check(f, {RESULT_B, RESULT_A});
        // partial read overrun
        #1 CHANNEL_ORDER_SELECT = 1'b0;
        convert(1'b1, 0);
        host.ser_read(8, 0, 1, f);
        check(f[7:0], RESULT_A[15:8]);
        o = n_ovr;
        RESULT_A = 16'h1234;
        convert(1'b1, 0);
        check(n_ovr - o, 1);
        #1 host.done_read();
        host.stray(5);
        host.ser_read(32, 0, 0, f);
        check(f, {16'h1234, RESULT_B});
        // internal clock, read after conversion
        #1 CLOCK_SOURCE_SELECT = 1'b0;
        convert(1'b1, 0);
        host.int_read(f, n);
        check(f, {16'h1234, RESULT_B});
        check(n, 32);
        final_report();
    end
endmodule

// ==== verilog/dsac_link_slave.sv ====
// dsac_link_slave.sv: serial slave shifter on the host's serial clock
// assumes: sclk may also run outside a frame; clr is high while chip select is off
`timescale 1ns/1ps
`include "dsac_map.svh"
module dsac_link_slave
    import dsac_pkg::*;
(
    input  wire logic        sclk,
    input  wire logic        clr,
    input  wire dsac_frame_t frame,
    output logic             sdo_r,
    output logic             reading_r
);
    localparam logic [`DSAC_BITCNT_W-1:0] LAST_BIT = `DSAC_BITCNT_W'(`DSAC_FRAME_W);

    logic [`DSAC_BITCNT_W-1:0] cnt_r;
    dsac_frame_t               sh_r;

    // chip select off holds everything clear, so stray edges do nothing
    always_ff @(posedge sclk or posedge clr) begin
        if (clr) begin
            cnt_r     <= '0;
            sh_r      <= '0;
            sdo_r     <= 1'b0;
            reading_r <= 1'b0;
        end else if (cnt_r == '0) begin
            // frame is stable here: it only changes at a latch
            sh_r      <= {frame[`DSAC_FRAME_W-2:0], 1'b0};
            sdo_r     <= frame[`DSAC_FRAME_W-1]; // msb first
            cnt_r     <= cnt_r + 1'b1;
            reading_r <= 1'b1;
        end else if (cnt_r != LAST_BIT) begin
            sh_r      <= {sh_r[`DSAC_FRAME_W-2:0], 1'b0};
            sdo_r     <= sh_r[`DSAC_FRAME_W-1];
            cnt_r     <= cnt_r + 1'b1;
            reading_r <= (cnt_r != LAST_BIT - 1'b1);
        end
    end
endmodule

// ==== verilog/dsac_map.svh ====
// dsac_map.svh: timing counts and frame layout of the converter control port
// assumes: included by bare name; CLOCK period below matches the real clock
`ifndef DSAC_MAP_SVH
`define DSAC_MAP_SVH

// clock period of CLOCK in ns (10 MHz)
`define DSAC_CLK_NS 100

// conversion time of one channel, ns
`define DSAC_TCONV_NS 400
// least time a conversion takes rounds up
`define DSAC_CONV_CYC ((`DSAC_TCONV_NS + `DSAC_CLK_NS - 1) / `DSAC_CLK_NS)

// acquisition phase in impulse mode, ns
`define DSAC_TACQ_NS 250
`define DSAC_ACQ_CYC ((`DSAC_TACQ_NS + `DSAC_CLK_NS - 1) / `DSAC_CLK_NS)

// half period of the internal serial clock, ns
`define DSAC_TSCLK_HALF_NS 100
`define DSAC_SCLK_HALF ((`DSAC_TSCLK_HALF_NS + `DSAC_CLK_NS - 1) / `DSAC_CLK_NS)

// width of timing counters
`define DSAC_CNT_W 8

// one result word, and the shift register holding both
`define DSAC_WORD_W  16
`define DSAC_FRAME_W 32
// top four parallel bits float in serial mode
`define DSAC_HI_LSB  12
// shared pin: bit 11 or the read overrun flag
`define DSAC_FLAG_BIT 11
// width of the bit counter of a serial frame
`define DSAC_BITCNT_W 6

`endif

// ==== verilog/dsac_pkg.sv ====
// dsac_pkg.sv: types shared by the converter control port
// assumes: dsac_map.svh is on the include path
`include "dsac_map.svh"
package dsac_pkg;

    // conversion sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_CONV_A = 5'h02,
        ST_CONV_B = 5'h04,
        ST_LATCH  = 5'h08,
        ST_ACQ    = 5'h10
    } dsac_state_t;

    // control pins, carried together through the synchroniser
    typedef struct packed {
        logic convert_start_n_n;
        logic pd;
        logic impulse;
        logic dev_rst;
        logic cs_n;
        logic rd_n;
        logic ser;
        logic ext;
        logic rdc;
        logic chsel;
    } dsac_pins_t;

    typedef logic [`DSAC_FRAME_W-1:0] dsac_frame_t;

endpackage

// ==== verilog/dsac_sync2.sv ====
// dsac_sync2.sv: two flip-flop level synchroniser, any width
// assumes: each bit is a slow level; bits are not sampled as one word
`timescale 1ns/1ps
module dsac_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1_r;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= '0;
            q        <= '0;
        end else begin
            stage1_r <= d;
            q        <= stage1_r;
        end
    end
endmodule

// ==== verilog/dsac_top.sv ====
// dsac_top.sv: conversion sequencer and result port of a two-channel
// simultaneous-sampling converter, parallel or serial
// assumes: control pins are asynchronous to CLOCK; RESULT_A/B come from the
// converter core on CLOCK and are valid while the latch state is active
`timescale 1ns/1ps
`include "dsac_map.svh"
// Behaviour
// - slave read overrun: data lost, flag pulsed
// - serial mode: top four parallel bits float
// - busy from start until results latched
// - end-of-convert low once per channel
// - drivers on only with select and read low, except the flag pin, always driven in slave serial mode, and the clock pin in master serial mode
// - chip select gates the external serial clock
// - reset input aborts conversion, clears logic
// - power-down: finish current, refuse new starts
// - start falling edge: hold and convert
// - impulse mode: start low after acquisition converts
// - shared pin: bit 11 or overrun flag
// - 32-bit register, msb first, order selectable
// - internal clock: read mode picks when output
module dsac_top
    import dsac_pkg::*;
#(
    parameter int CONV_CYC = `DSAC_CONV_CYC,
    parameter int ACQ_CYC  = `DSAC_ACQ_CYC,
    parameter int SCLK_HALF = `DSAC_SCLK_HALF
) (
    // system clock and reset
    input  wire logic                      CLOCK,
    input  wire logic                      RESET_N,
    // conversion control pins
    input  wire logic                      CONVERT_START_N,
    input  wire logic                      POWER_DOWN,
    input  wire logic                      IMPULSE_MODE,
    input  wire logic                      DEVICE_RESET,
    // read strobes
    input  wire logic                      CS_N,
    input  wire logic                      RD_N,
    // interface mode straps
    input  wire logic                      SERIAL_PARALLEL_SELECT,
    input  wire logic                      CLOCK_SOURCE_SELECT,
    input  wire logic                      READ_MODE_OR_CHAIN_IN,
    input  wire logic                      CHANNEL_ORDER_SELECT,
    // results from the converter core
    input  wire logic [`DSAC_WORD_W-1:0]   RESULT_A,
    input  wire logic [`DSAC_WORD_W-1:0]   RESULT_B,
    // conversion status
    output logic                           BUSY,
    output logic                           END_OF_CONVERT_N,
    // parallel bus, bit 11 shared with the overrun flag
    output logic [`DSAC_WORD_W-1:0]        DATA_OUT,
    output logic [`DSAC_WORD_W-1:0]        DATA_OE,
    // serial port
    input  wire logic                      SCLK_IN,
    output logic                           SCLK_OUT,
    output logic                           SCLK_OE,
    output logic                           SERIAL_RESULT_OUT,
    output logic                           SERIAL_OE
);
    localparam logic [`DSAC_CNT_W-1:0] CONV_LAST = `DSAC_CNT_W'(CONV_CYC - 1);
    localparam logic [`DSAC_CNT_W-1:0] ACQ_LAST  = `DSAC_CNT_W'(ACQ_CYC - 1);
    localparam logic [`DSAC_CNT_W-1:0] HALF_LAST = `DSAC_CNT_W'(SCLK_HALF - 1);
    localparam logic [`DSAC_BITCNT_W-1:0] BIT_LAST =
        `DSAC_BITCNT_W'(`DSAC_FRAME_W - 1);

    // synchronised pins
    dsac_pins_t pins_raw;
    dsac_pins_t pins_s;

    // sequencer
    dsac_state_t             state_r;
    logic [`DSAC_CNT_W-1:0]  cnt_r;
    logic                    cnv_prev_r;
    logic                    cnv_fall;
    logic                    conv_done;
    logic                    acq_done;
    logic                    start_go;
    logic                    latch_go;
    logic                    busy_r;
    logic                    eoc_n_r;

    // result storage
    dsac_frame_t             frame_r;
    logic                    ovr_r;

    // parallel read
    logic                    rd_en_s;
    logic                    rd_en_prev_r;
    logic                    read_end;
    logic                    par_hi_r;
    logic [`DSAC_WORD_W-1:0] data_r;
    logic                    out_en;

    // internal serial clock master
    logic                    ms_busy_r;
    logic                    ms_sent_r;
    logic [`DSAC_CNT_W-1:0]  ms_div_r;
    logic [`DSAC_BITCNT_W-1:0] ms_cnt_r;
    dsac_frame_t             ms_sh_r;
    logic                    ms_sdo_r;
    logic                    sclk_r;
    logic                    ms_avail;
    logic                    ms_go;

    // external serial clock slave
    logic                    link_clr;
    logic                    link_sdo;
    logic                    link_reading;
    logic                    reading_s;

    // all control pins come from outside, two flops before use; raw CS_N and RD_N also gate the drivers, and raw CS_N alone the slave clear
    assign pins_raw = '{
        convert_start_n_n: CONVERT_START_N,
        pd:      POWER_DOWN,
        impulse: IMPULSE_MODE,
        dev_rst: DEVICE_RESET,
        cs_n:    CS_N,
        rd_n:    RD_N,
        ser:     SERIAL_PARALLEL_SELECT,
        ext:     CLOCK_SOURCE_SELECT,
        rdc:     READ_MODE_OR_CHAIN_IN,
        chsel:   CHANNEL_ORDER_SELECT
    };

    dsac_sync2 #(
        .W ($bits(dsac_pins_t))
    ) u_pin_sync (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .d     (pins_raw),
        .q     (pins_s)
    );

    // start detection; synced start resets low so reset gives no false edge
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnv_prev_r <= 1'b0;
        end else begin
            cnv_prev_r <= pins_s.convert_start_n_n;
        end
    end

    assign cnv_fall  = cnv_prev_r & ~pins_s.convert_start_n_n;
    assign conv_done = (cnt_r == CONV_LAST);
    assign acq_done  = (cnt_r == ACQ_LAST);
    assign latch_go  = (state_r == ST_LATCH) & ~pins_s.dev_rst;

    // a start from idle on a falling edge, or at the end of acquisition while
    // start is still low; power-down refuses both
    always_comb begin
        start_go = 1'b0;
        if (state_r == ST_IDLE) begin
            start_go = cnv_fall;
        end else if (state_r == ST_ACQ) begin
            start_go = acq_done & ~pins_s.convert_start_n_n;
        end
        if (pins_s.pd || pins_s.dev_rst) begin
            start_go = 1'b0;
        end
    end

    // conversion sequencer: channel a, channel b, latch, optional acquisition
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else if (pins_s.dev_rst) begin
            state_r <= ST_IDLE; // abort whatever runs
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    cnt_r <= '0;
                    if (start_go) begin
                        state_r <= ST_CONV_A;
                    end
                end
                ST_CONV_A: begin
                    if (conv_done) begin
                        state_r <= ST_CONV_B;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_CONV_B: begin
                    if (conv_done) begin
                        state_r <= ST_LATCH;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_LATCH: begin
                    // power scaled mode rests in acquisition before the next
                    state_r <= pins_s.impulse ? ST_ACQ : ST_IDLE;
                    cnt_r   <= '0;
                end
                ST_ACQ: begin
                    if (acq_done) begin
                        state_r <= start_go ? ST_CONV_A : ST_IDLE;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    // busy: up with the start, down with the latch; idle low after reset
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_r <= 1'b0;
        end else if (pins_s.dev_rst) begin
            busy_r <= 1'b0;
        end else if (start_go) begin
            busy_r <= 1'b1;
        end else if (latch_go) begin
            busy_r <= 1'b0; // falling edge marks fresh data
        end
    end

    // one low cycle as each channel finishes
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            eoc_n_r <= 1'b1;
        end else begin
            eoc_n_r <= ~(conv_done & ~pins_s.dev_rst &
                         ((state_r == ST_CONV_A) | (state_r == ST_CONV_B)));
        end
    end

    // both results go into the frame; channel order follows the select input
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            frame_r <= '0;
        end else if (latch_go) begin
            frame_r <= pins_s.chsel ? {RESULT_B, RESULT_A} : {RESULT_A, RESULT_B};
        end
    end

    // a slave read still running when new data lands loses its data
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ovr_r <= 1'b0;
        end else begin
            ovr_r <= latch_go & pins_s.ser & pins_s.ext & reading_s;
        end
    end

    // parallel read: first word, then each completed read switches to the other word
    assign rd_en_s  = ~pins_s.cs_n & ~pins_s.rd_n;
    assign read_end = rd_en_prev_r & ~rd_en_s;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_en_prev_r <= 1'b0;
            par_hi_r     <= 1'b0;
        end else begin
            rd_en_prev_r <= rd_en_s;
            if (latch_go) begin
                par_hi_r <= 1'b0;
            end else if (read_end && !pins_s.ser) begin
                par_hi_r <= ~par_hi_r;
            end
        end
    end

    // registered parallel data; the shared pin turns flag in slave serial mode
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            data_r <= '0;
        end else begin
            data_r <= par_hi_r ? frame_r[`DSAC_WORD_W-1:0]
                               : frame_r[`DSAC_FRAME_W-1:`DSAC_WORD_W];
            if (pins_s.ser && pins_s.ext) begin
                data_r[`DSAC_FLAG_BIT] <= ovr_r;
            end
        end
    end

    // internal clock: previous data at any time, or only once conversion ends
    assign ms_avail = pins_s.rdc | ~busy_r;
    assign ms_go    = pins_s.ser & ~pins_s.ext & rd_en_s & ~ms_sent_r &
                      ms_avail & ~ms_busy_r;

    // sent flag: set after a full frame, cleared by new data
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ms_sent_r <= 1'b1;
        end else if (latch_go) begin
            ms_sent_r <= 1'b0;
        end else if (ms_busy_r && sclk_r && ms_div_r == HALF_LAST &&
                     ms_cnt_r == BIT_LAST) begin
            ms_sent_r <= 1'b1;
        end
    end

    // serial master: divided clock, bit changes as the clock falls
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ms_busy_r <= 1'b0;
            ms_div_r  <= '0;
            ms_cnt_r  <= '0;
            ms_sh_r   <= '0;
            ms_sdo_r  <= 1'b0;
            sclk_r    <= 1'b0;
        end else if (ms_go) begin
            ms_busy_r <= 1'b1;
            ms_div_r  <= '0;
            ms_cnt_r  <= '0;
            ms_sh_r   <= {frame_r[`DSAC_FRAME_W-2:0], 1'b0};
            ms_sdo_r  <= frame_r[`DSAC_FRAME_W-1]; // msb first
            sclk_r    <= 1'b0;
        end else if (ms_busy_r) begin
            if (!rd_en_s || pins_s.dev_rst) begin
                ms_busy_r <= 1'b0; // host dropped the read, stop clean
                sclk_r    <= 1'b0;
            end else if (ms_div_r != HALF_LAST) begin
                ms_div_r <= ms_div_r + 1'b1;
            end else begin
                ms_div_r <= '0;
                sclk_r   <= ~sclk_r;
                if (sclk_r) begin
                    if (ms_cnt_r == BIT_LAST) begin
                        ms_busy_r <= 1'b0;
                    end else begin
                        ms_cnt_r <= ms_cnt_r + 1'b1;
                        ms_sdo_r <= ms_sh_r[`DSAC_FRAME_W-1];
                        ms_sh_r  <= {ms_sh_r[`DSAC_FRAME_W-2:0], 1'b0};
                    end
                end
            end
        end
    end

    // slave shifter lives on the host clock; chip select clears it
    assign link_clr = CS_N | ~RESET_N;

    dsac_link_slave u_link (
        .sclk      (SCLK_IN),
        .clr       (link_clr),
        .frame     (frame_r),
        .sdo_r     (link_sdo),
        .reading_r (link_reading)
    );

    // read-in-progress level crosses back into the CLOCK domain
    dsac_sync2 #(
        .W (1)
    ) u_read_sync (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .d     (link_reading),
        .q     (reading_s)
    );

    // drivers follow the raw strobes so they release at once
    assign out_en = ~CS_N & ~RD_N;

    always_comb begin
        DATA_OE = {`DSAC_WORD_W{~pins_s.ser & out_en}};
        DATA_OE[`DSAC_WORD_W-1:`DSAC_HI_LSB] =
            {(`DSAC_WORD_W - `DSAC_HI_LSB){~pins_s.ser & out_en}};
        if (pins_s.ser && pins_s.ext) begin
            DATA_OE[`DSAC_FLAG_BIT] = 1'b1; // flag pin always driven
        end
    end

    // status and data outputs
    assign BUSY              = busy_r;
    assign END_OF_CONVERT_N  = eoc_n_r;
    assign DATA_OUT          = data_r;
    assign SCLK_OUT          = sclk_r;
    assign SCLK_OE           = pins_s.ser & ~pins_s.ext;
    assign SERIAL_RESULT_OUT = pins_s.ext ? link_sdo : ms_sdo_r;
    assign SERIAL_OE         = pins_s.ser & out_en;
endmodule
